// ---- uct_regs.vh ----
`ifndef UCT_REGS_VH
`define UCT_REGS_VH
`define UCT_A_CMD 8'h00
`define UCT_A_MODE 8'h04
`define UCT_A_STAT 8'h08
`define UCT_A_RHR 8'h0C
`define UCT_A_THR 8'h10
`define UCT_A_GUARD 8'h14
`define UCT_A_DIV 8'h18
`define UCT_C_CLR 0
`define UCT_C_RECEIVER_ENABLE_CMD 1
`define UCT_C_RXDIS 2
`define UCT_C_TRANSMITTER_ENABLE_CMD 3
`define UCT_C_TXDIS 4
`define UCT_C_ADDR 5
`define UCT_M_LEN 1:0
`define UCT_M_NINE 2
`define UCT_M_MSB 3
`define UCT_M_PAR 6:4
`define UCT_M_STOP 8:7
`define UCT_M_SYNC 9
`define UCT_M_OVER 10
`define UCT_MODE_RST 11'h003
`define UCT_GUARD_RST 8'h00
`define UCT_DIV_RST 16'h0001
`define UCT_P_EVEN 3'h0
`define UCT_P_ODD 3'h1
`define UCT_P_SPACE 3'h2
`define UCT_P_MARK 3'h3
`define UCT_P_NONE0 3'h4
`define UCT_P_NONE1 3'h5
`define UCT_ST_15 2'h1
`define UCT_ST_2 2'h2
`define UCT_OVS_16 5'h10
`define UCT_OVS_8 5'h08
`endif

// ---- uct_core.v ----
`timescale 1ns/1ns
`include "uct_regs.vh"
module uct_core #(
  parameter AW = 8
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [AW-1:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  // Serial link
  input wire rxd_i,
  output reg txd_o,
  output reg sclk_o
);

////////////////////////////////////////////////////////////////////////
localparam T_IDLE = 6'h01;
localparam T_START = 6'h02;
localparam T_DATA = 6'h04;
localparam T_PAR = 6'h08;
localparam T_STOP = 6'h10;
localparam T_GUARD = 6'h20;
localparam R_IDLE = 4'h1;
localparam R_DATA = 4'h2;
localparam R_PAR = 4'h4;
localparam R_STOP = 4'h8;

function [3:0] uct_nbits;
  input [1:0] len;
  input nine;
  begin
    uct_nbits = nine ? 4'h9 : ({2'h0, len} + 4'h5);
  end
endfunction

function [8:0] uct_rev;
  input [8:0] d;
  input [3:0] n;
  integer i;
  begin
    uct_rev = 9'h000;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < n) begin
        uct_rev[n - 1 - i] = d[i];
      end
    end
  end
endfunction

function uct_pgen;
  input [2:0] p;
  input x;
  input a;
  begin
    case (p)
      `UCT_P_EVEN: uct_pgen = x;
      `UCT_P_ODD: uct_pgen = ~x;
      `UCT_P_SPACE: uct_pgen = 1'b0;
      `UCT_P_MARK: uct_pgen = 1'b1;
      default: uct_pgen = a;
    endcase
  end
endfunction

function uct_perr;
  input [2:0] p;
  input x;
  input b;
  begin
    case (p)
      `UCT_P_EVEN: uct_perr = b ^ x;
      `UCT_P_ODD: uct_perr = ~(b ^ x);
      `UCT_P_SPACE: uct_perr = b;
      `UCT_P_MARK: uct_perr = ~b;
      `UCT_P_NONE0: uct_perr = 1'b0;
      `UCT_P_NONE1: uct_perr = 1'b0;
      default: uct_perr = b;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////
reg [10:0] mode;
reg [7:0] guard;
reg [15:0] div;
reg rx_en;
reg tx_en;
reg rx_rdy;
reg ovr;
reg perr;
reg [8:0] receive_holding_reg;
reg [8:0] transmit_holding_reg;
reg thr_full;
reg thr_addr;
reg addr_pend;
reg ap_pend;
reg ap_wr;
reg [AW-1:0] ap_addr;
reg [31:0] rdv;

wire sync = mode[`UCT_M_SYNC];
wire [2:0] par = mode[`UCT_M_PAR];
wire [3:0] nb = uct_nbits(mode[`UCT_M_LEN], mode[`UCT_M_NINE]);
wire bit_order_select = mode[`UCT_M_MSB];
wire has_par = (par != `UCT_P_NONE0) && (par != `UCT_P_NONE1);
wire [4:0] ovs = mode[`UCT_M_OVER] ? `UCT_OVS_8 : `UCT_OVS_16;
wire [8:0] dmask = ~(9'h1FF << nb);
wire tx_rdy = tx_en & ~thr_full;
wire ap_take = hsel_i & htrans_i[1] & hready_i;

////////////////////////////////////////////////////////////////////////
// Sample-rate divider; zero divisor stops all ticks
reg [15:0] dcnt;
reg stick;

always @(posedge clk_sys_i) begin
  if (reset_i) begin
    dcnt <= 16'h0000;
    stick <= 1'b0;
  end else begin
    stick <= 1'b0;
    if (div == 16'h0000) begin
      dcnt <= 16'h0000;
    end else if (dcnt >= div - 16'h0001) begin
      dcnt <= 16'h0000;
      stick <= 1'b1;
    end else begin
      dcnt <= dcnt + 16'h0001;
    end
  end
end

// Half-bit ticks: the serial clock edges in sync mode
reg [3:0] hcnt;
reg bph;
wire htick = stick & (sync | (hcnt == ovs[4:1] - 4'h1));
wire rise = htick & ~bph;

always @(posedge clk_sys_i) begin
  if (reset_i) begin
    hcnt <= 4'h0;
    bph <= 1'b0;
    sclk_o <= 1'b1;
  end else begin
    if (stick) begin
      hcnt <= (sync | (hcnt == ovs[4:1] - 4'h1)) ? 4'h0 : hcnt + 4'h1;
    end
    if (htick) begin
      bph <= ~bph;
    end
    sclk_o <= sync ? (htick ? ~bph : bph) : 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// Transmitter, paced in half bits so 1.5 stop fits
reg [5:0] tst;
reg [8:0] thc;
reg [8:0] tsh;
reg [3:0] tn;
reg tpar;
wire [8:0] stop_h = ((mode[`UCT_M_STOP] == `UCT_ST_15) && !sync) ? 9'h003 :
  (mode[`UCT_M_STOP] == `UCT_ST_2) ? 9'h004 : 9'h002;
wire bit_end = (thc == 9'h001);
wire stop_end = (tst == T_STOP) && (thc == stop_h - 9'h001);
// Guard is counted in half bits, two per programmed bit period
wire guard_end = (tst == T_GUARD) && (thc == {guard, 1'b0} - 9'h001);
wire tx_fin = (stop_end && (guard == 8'h00)) || guard_end;
// Back-to-back start keeps the sync clock aligned
wire tx_load = htick & thr_full &
  (((tst == T_IDLE) && (!sync || bph)) || tx_fin);

always @(posedge clk_sys_i) begin
  if (reset_i) begin
    tst <= T_IDLE;
    thc <= 9'h000;
    tsh <= 9'h000;
    tn <= 4'h0;
    tpar <= 1'b0;
    txd_o <= 1'b1;
  end else if (tx_load) begin
    txd_o <= 1'b0;
    tsh <= bit_order_select ? uct_rev(transmit_holding_reg, nb) : transmit_holding_reg;
    tn <= nb;
    tpar <= uct_pgen(par, ^(transmit_holding_reg & dmask), thr_addr);
    thc <= 9'h000;
    tst <= T_START;
  end else if (htick) begin
    thc <= thc + 9'h001;
    case (tst)
      T_IDLE: begin
        thc <= 9'h000;
        txd_o <= 1'b1;
      end
      T_START: begin
        if (bit_end) begin
          txd_o <= tsh[0];
          tsh <= tsh >> 1;
          tn <= tn - 4'h1;
          thc <= 9'h000;
          tst <= T_DATA;
        end
      end
      T_DATA: begin
        if (bit_end) begin
          thc <= 9'h000;
          if (tn != 4'h0) begin
            txd_o <= tsh[0];
            tsh <= tsh >> 1;
            tn <= tn - 4'h1;
          end else if (has_par) begin
            txd_o <= tpar;
            tst <= T_PAR;
          end else begin
            txd_o <= 1'b1;
            tst <= T_STOP;
          end
        end
      end
      T_PAR: begin
        if (bit_end) begin
          txd_o <= 1'b1;
          thc <= 9'h000;
          tst <= T_STOP;
        end
      end
      T_STOP: begin
        if (stop_end) begin
          thc <= 9'h000;
          tst <= (guard == 8'h00) ? T_IDLE : T_GUARD;
        end
      end
      T_GUARD: begin
        if (guard_end) begin
          thc <= 9'h000;
          tst <= T_IDLE;
        end
      end
      default: begin
        tst <= T_IDLE;
        txd_o <= 1'b1;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Receiver
reg [3:0] rst_q;
reg [4:0] rc;
reg [8:0] rsh;
reg [3:0] rn;
reg [3:0] rnt;
reg rpx;
reg rpb;
wire rbit = sync ? rise : (stick && (rc == ovs - 5'h01));
wire rx_done = rbit && (rst_q == R_STOP);
wire [8:0] ralign = rsh >> (4'h9 - rnt);
wire [8:0] rchar = bit_order_select ? uct_rev(ralign, rnt) : ralign;
wire rx_perr = has_par && uct_perr(par, rpx, rpb);

always @(posedge clk_sys_i) begin
  if (reset_i) begin
    rst_q <= R_IDLE;
    rc <= 5'h00;
    rsh <= 9'h000;
    rn <= 4'h0;
    rnt <= 4'h0;
    rpx <= 1'b0;
    rpb <= 1'b0;
  end else begin
    if (stick && (rst_q != R_IDLE)) begin
      rc <= (rc == ovs - 5'h01) ? 5'h00 : rc + 5'h01;
    end
    case (rst_q)
      R_IDLE: begin
        rn <= nb;
        rnt <= nb;
        rpx <= 1'b0;
        if (sync) begin
          rc <= 5'h00;
          if (rise && rx_en && !rxd_i) begin
            rst_q <= R_DATA;
          end
        end else if (stick) begin
          if (rxd_i || !rx_en) begin
            rc <= 5'h00;
          end else if (rc == ovs[4:1] - 5'h01) begin
            rc <= 5'h00;
            rst_q <= R_DATA;
          end else begin
            rc <= rc + 5'h01;
          end
        end
      end
      R_DATA: begin
        if (rbit) begin
          rsh <= {rxd_i, rsh[8:1]};
          rpx <= rpx ^ rxd_i;
          rn <= rn - 4'h1;
          if (rn == 4'h1) begin
            rst_q <= has_par ? R_PAR : R_STOP;
          end
        end
      end
      R_PAR: begin
        if (rbit) begin
          rpb <= rxd_i;
          rst_q <= R_STOP;
        end
      end
      R_STOP: begin
        if (rbit) begin
          rc <= 5'h00;
          rst_q <= R_IDLE;
        end
      end
      default: begin
        rst_q <= R_IDLE;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Register file; one wait state so read data leaves a flop
always @* begin
  rdv = 32'h00000000;
  case (ap_addr)
    `UCT_A_MODE: rdv = {21'h000000, mode};
    `UCT_A_STAT: rdv = {25'h0000000, tx_en, rx_en,
      tx_rdy & (tst == T_IDLE), perr, ovr, tx_rdy, rx_rdy};
    `UCT_A_RHR: rdv = {23'h000000, receive_holding_reg};
    `UCT_A_GUARD: rdv = {24'h000000, guard};
    `UCT_A_DIV: rdv = {16'h0000, div};
    default: rdv = 32'h00000000;
  endcase
end

wire rd_rhr = ap_pend && !ap_wr && (ap_addr == `UCT_A_RHR);
wire wr_cmd = ap_pend && ap_wr && (ap_addr == `UCT_A_CMD);

always @(posedge clk_sys_i) begin
  if (reset_i) begin
    mode <= `UCT_MODE_RST;
    guard <= `UCT_GUARD_RST;
    div <= `UCT_DIV_RST;
    rx_en <= 1'b0;
    tx_en <= 1'b0;
    rx_rdy <= 1'b0;
    ovr <= 1'b0;
    perr <= 1'b0;
    receive_holding_reg <= 9'h000;
    transmit_holding_reg <= 9'h000;
    thr_full <= 1'b0;
    thr_addr <= 1'b0;
    addr_pend <= 1'b0;
    ap_pend <= 1'b0;
    ap_wr <= 1'b0;
    ap_addr <= {AW{1'b0}};
    hrdata_o <= 32'h00000000;
    hreadyout_o <= 1'b1;
    hresp_o <= 1'b0;
  end else begin
    if (ap_take) begin
      ap_pend <= 1'b1;
      ap_wr <= hwrite_i;
      ap_addr <= haddr_i;
      hreadyout_o <= 1'b0;
    end
    if (ap_pend) begin
      ap_pend <= 1'b0;
      hreadyout_o <= 1'b1;
      if (!ap_wr) begin
        hrdata_o <= rdv;
      end
    end
    if (tx_load) begin
      thr_full <= 1'b0;
    end
    if (rd_rhr) begin
      rx_rdy <= 1'b0;
    end
    if (ap_pend && ap_wr) begin
      case (ap_addr)
        `UCT_A_MODE: mode <= hwdata_i[10:0];
        `UCT_A_GUARD: guard <= hwdata_i[7:0];
        `UCT_A_DIV: div <= hwdata_i[15:0];
        `UCT_A_THR: begin
          if (tx_rdy) begin
            transmit_holding_reg <= hwdata_i[8:0];
            thr_full <= 1'b1;
            thr_addr <= addr_pend;
            addr_pend <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (wr_cmd) begin
      if (hwdata_i[`UCT_C_CLR]) begin
        ovr <= 1'b0;
        perr <= 1'b0;
      end
      if (hwdata_i[`UCT_C_RECEIVER_ENABLE_CMD]) begin
        rx_en <= 1'b1;
      end
      if (hwdata_i[`UCT_C_RXDIS]) begin
        rx_en <= 1'b0;
      end
      if (hwdata_i[`UCT_C_TRANSMITTER_ENABLE_CMD]) begin
        tx_en <= 1'b1;
      end
      if (hwdata_i[`UCT_C_TXDIS]) begin
        tx_en <= 1'b0;
      end
      if (hwdata_i[`UCT_C_ADDR]) begin
        addr_pend <= 1'b1;
      end
    end
    // Hardware sets come last so they beat a same-cycle clear
    if (rx_done) begin
      receive_holding_reg <= rchar;
      rx_rdy <= 1'b1;
      if (rx_rdy && !rd_rhr) begin
        ovr <= 1'b1;
      end
      if (rx_perr) begin
        perr <= 1'b1;
      end
    end
  end
end

endmodule

// ---- uct_core_props.sv ----
`timescale 1ns/1ns
module uct_core_props #(
  parameter AW = 8
) (
  // Clock and bus
  input wire clk_sys_i,
  input wire reset_i,
  input wire hsel_i,
  input wire [AW-1:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  // Serial
  input wire txd_o,
  input wire sclk_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire take = hsel_i && htrans_i[1] && hready_i;
  logic wph;
  logic ten;
  ////////////////////////////////////////////////////////////
  // Shadow of tx enable; disable wins over enable
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      wph <= 1'b0;
      ten <= 1'b0;
    end else begin
      wph <= take && hwrite_i && haddr_i == 8'h00;
      if (wph && hwdata_i[4]) begin
        ten <= 1'b0;
      end else if (wph && hwdata_i[3]) begin
        ten <= 1'b1;
      end
    end
  end
  sequence one_wait;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  sequence rd_at(a);
    take && !hwrite_i && haddr_i == a ##1 one_wait;
  endsequence
  ////////////////////////////////////////////////////////////
  bus_wait_a: assert property (take |=> one_wait)
    else $error("transfer without one wait state");
  okay_resp_a: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  unmapped_zero_a: assert property (rd_at(8'h1C) |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  tx_flags_a: assert property (rd_at(8'h08) |-> hrdata_o[6] == ten &&
    (ten || !hrdata_o[1] && !hrdata_o[4])) else $error("tx flags while disabled");
  reset_idle_a: assert property (disable iff (1'b0)
    reset_i |=> txd_o && sclk_o && hreadyout_o && !hresp_o && hrdata_o == 32'h0)
    else $error("not idle after reset");
  bit_hold_a: assert property ($changed(txd_o) |=> $stable(txd_o))
    else $error("serial bit too short");
  sclk_edge_a: assert property ($changed(txd_o) |-> !sclk_o || $stable(sclk_o))
    else $error("tx bit not on falling clock");
  idle_ready_a: assert property (!take && hreadyout_o |=> hreadyout_o)
    else $error("wait state without transfer");
endmodule
bind uct_core uct_core_props #(.AW(AW)) u_props (
  .clk_sys_i(clk_sys_i),
  .reset_i(reset_i),
  .hsel_i(hsel_i),
  .haddr_i(haddr_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .hwdata_i(hwdata_i),
  .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .txd_o(txd_o),
  .sclk_o(sclk_o)
);

// ---- uct_remote.sv ----
`timescale 1ns/1ns
module uct_remote (
  input wire clk_sys_i,
  input wire line_i,
  output logic line_o
);
  int bitlen = 16;
  logic [11:0] q[$];
  logic [11:0] cap;
  time st[$];
  initial line_o = 1'b1;
  // Mid-bit sampling; last sample stops early so a following start is not missed
  always begin
    @(negedge line_i);
    st.push_back($time);
    repeat (bitlen / 2) @(posedge clk_sys_i);
    for (int i = 0; i < 12; i++) begin
      cap[i] = line_i;
      if (i < 11) repeat (bitlen) @(posedge clk_sys_i);
    end
    q.push_back(cap);
  end
  task send(input logic [11:0] f, input int gap);
    repeat (gap) @(posedge clk_sys_i);
    for (int i = 0; i < 12; i++) begin
      line_o <= f[i];
      repeat (bitlen) @(posedge clk_sys_i);
    end
  endtask
endmodule

// ---- test_usart_char_tx_rx_parity.sv ----
`timescale 1ns/1ns
`include "uct_regs.vh"
module test_usart_char_tx_rx_parity;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  logic [31:0] r;
  logic [31:0] seed = 32'h00006FDC;
  logic [10:0] m;
  logic [11:0] e;
  logic bad;
  time tg;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, txd_o, sclk_o, rxd;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  uct_core u_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hready_i(hreadyout_o), .hwdata_i(hwdata),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .rxd_i(rxd), .txd_o(txd_o), .sclk_o(sclk_o));
  uct_remote u_rem (.clk_sys_i(clk_sys_i), .line_i(txd_o), .line_o(rxd));
  ////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function int nb(input logic [10:0] md);
    return md[2] ? 9 : 5 + md[1:0];
  endfunction
  function logic [11:0] frame(input logic [8:0] d, input logic [10:0] md, input logic a);
    int n;
    logic x;
    n = nb(md);
    x = 1'b0;
    frame = 12'hFFE;
    for (int i = 0; i < n; i++) begin
      frame[1 + i] = md[3] ? d[n - 1 - i] : d[i];
      x ^= d[i];
    end
    case (md[6:4])
      3'h0: frame[1 + n] = x;
      3'h1: frame[1 + n] = ~x;
      3'h2: frame[1 + n] = 1'b0;
      3'h3: frame[1 + n] = 1'b1;
      3'h6, 3'h7: frame[1 + n] = a;
      default: ;
    endcase
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] x, input string s);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, g, x);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_sys_i);
    q = hrdata_o;
  endtask
  task poll(input int b);
    for (int k = 0; k < 80; k++) begin
      bus(1'b0, `UCT_A_STAT, 32'h0);
      if (q[b]) break;
    end
  endtask
  task txf(input logic [11:0] x);
    logic [11:0] f;
    f = 'x;
    for (int k = 0; k < 600 && u_rem.q.size() == 0; k++) @(posedge clk_sys_i);
    if (u_rem.q.size() > 0) f = u_rem.q.pop_front();
    chk({20'h0, f}, {20'h0, x}, "frame");
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    hsel <= 1'b1;
    bus(1'b0, `UCT_A_STAT, 32'h0);
    chk(q, 32'h0, "status at reset");
    bus(1'b0, `UCT_A_MODE, 32'h0);
    chk(q, 32'h3, "mode at reset");
    bus(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0, "unmapped");
    bus(1'b1, `UCT_A_THR, 32'h55);
    bus(1'b1, `UCT_A_CMD, 32'h0A);
    bus(1'b0, `UCT_A_STAT, 32'h0);
    chk(q, 32'h72, "status enabled");
    // Fixed window: a dropped write must never surface later
    repeat (300) @(posedge clk_sys_i);
    chk(u_rem.q.size(), 0, "dropped write");
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      m = {2'b00, r[8:7], i[2:0], r[3:0]};
      bus(1'b1, `UCT_A_MODE, {21'h0, m});
      if (m[6:5] == 2'b11 && i[3]) bus(1'b1, `UCT_A_CMD, 32'h20);
      bus(1'b1, `UCT_A_THR, {23'h0, r[20:12]});
      txf(frame(r[20:12], m, i[3]));
      poll(4);
    end
    $display("test transmit done");
    bus(1'b1, `UCT_A_MODE, 32'h43);
    bus(1'b1, `UCT_A_GUARD, 32'h2);
    bus(1'b1, `UCT_A_THR, 32'h0F);
    poll(1);
    bus(1'b1, `UCT_A_THR, 32'hF0);
    txf(frame(9'h0F, 11'h043, 1'b0));
    bus(1'b0, `UCT_A_STAT, 32'h0);
    chk(q & 32'h12, 32'h0, "guard flags");
    txf(frame(9'hF0, 11'h043, 1'b0));
    // Start to start: 1 start, 8 data, 1 stop, 2 guard bits of 16 clocks
    tg = u_rem.st[u_rem.st.size() - 1] - u_rem.st[u_rem.st.size() - 2];
    chk(32'(tg), 32'h780, "guard gap");
    poll(4);
    bus(1'b1, `UCT_A_GUARD, 32'h0);
    $display("test guard done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      m = {4'h0, i[2:0], r[3:0]};
      bad = r[5];
      e = frame(r[20:12], m, bad);
      if (i < 4) e[1 + nb(m)] ^= bad;
      bus(1'b1, `UCT_A_MODE, {21'h0, m});
      u_rem.send(e, r[27:24]);
      bus(1'b0, `UCT_A_STAT, 32'h0);
      chk(q & 32'hD, {28'h0, bad && (i < 4 || i > 5), 3'h1}, "rx status");
      bus(1'b0, `UCT_A_RHR, 32'h0);
      chk(q, {23'h0, r[20:12]} & (32'h1FF >> (9 - nb(m))), "rx data");
      bus(1'b1, `UCT_A_CMD, 32'h1);
    end
    $display("test receive done");
    u_rem.bitlen = 8;
    bus(1'b1, `UCT_A_MODE, 32'h443);
    u_rem.send(frame(9'hA5, 11'h443, 1'b0), 3);
    u_rem.send(frame(9'h3C, 11'h443, 1'b0), 0);
    bus(1'b0, `UCT_A_STAT, 32'h0);
    chk(q & 32'hD, 32'h5, "overrun");
    bus(1'b0, `UCT_A_RHR, 32'h0);
    chk(q, 32'h3C, "overwritten");
    u_rem.send(frame(9'h81, 11'h443, 1'b0), 0);
    bus(1'b0, `UCT_A_STAT, 32'h0);
    chk(q & 32'hD, 32'h5, "sticky");
    bus(1'b1, `UCT_A_CMD, 32'h1);
    bus(1'b0, `UCT_A_STAT, 32'h0);
    chk(q & 32'hD, 32'h1, "cleared");
    bus(1'b1, `UCT_A_THR, 32'h5A);
    txf(frame(9'h5A, 11'h443, 1'b0));
    $display("test overrun done");
    bus(1'b0, `UCT_A_RHR, 32'h0);
    chk(q, 32'h81, "last async");
    // Sync mode, divisor 2: one bit is 4 clocks
    bus(1'b1, `UCT_A_DIV, 32'h2);
    bus(1'b1, `UCT_A_MODE, 32'h20B);
    u_rem.bitlen = 4;
    bus(1'b1, `UCT_A_THR, 32'hC3);
    txf(frame(9'hC3, 11'h20B, 1'b0));
    u_rem.send(frame(9'h96, 11'h20B, 1'b0), 1);
    bus(1'b0, `UCT_A_STAT, 32'h0);
    chk(q & 32'hD, 32'h1, "sync rx status");
    bus(1'b0, `UCT_A_RHR, 32'h0);
    chk(q, 32'h96, "sync rx data");
    $display("test sync done");
    conclude();
  end
endmodule
